// >>> bench/ccrl_checker_properties.sv
// concurrent checks on the codec rate and configuration ports
`timescale 1ns/10ps
`default_nettype none
module ccrl_checker (
	// clock and reset
	input wire logic                 clock,
	input wire logic                 sys_rst,
	input wire logic                 codecResetN,
	// serial and converter
	input wire logic                 shiftClk,
	input wire logic                 txFrameSync,
	input wire logic                 txConvert,
	input wire logic                 rxConvert,
	input wire logic [13:0]          dacWord,
	// configuration
	input wire ccrl_pkg::ccrl_ctrl_t analogConfig,
	input wire logic                 shutdown,
	input wire logic                 portStopped
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst || !codecResetN);

	a_reset_config: assert property (
		$past(sys_rst || !codecResetN) |-> analogConfig == ccrl_pkg::RST_CTRL)
		else $error("control not at defaults after reset");
	a_reset_quiet: assert property (
		$past(sys_rst || !codecResetN) |-> !shutdown && !portStopped && !txFrameSync)
		else $error("status not clear after reset");
	a_shift_rate: assert property (
		$rose(shiftClk) |=> shiftClk ##1 !shiftClk [*2] ##1 shiftClk)
		else $error("shift clock not a quarter of the master clock");
	a_shut_frozen: assert property (
		shutdown && $past(shutdown) |-> !txConvert && !rxConvert)
		else $error("conversion while shut down");
	a_shut_stop: assert property (
		shutdown |-> portStopped)
		else $error("shut down without port stop");
	a_stop_frame: assert property (
		portStopped && $past(portStopped, 3) |-> !$rose(txFrameSync))
		else $error("frame started while port stopped");
	a_common_rx: assert property (
		analogConfig.common && $past(analogConfig.common, 2) |-> rxConvert == txConvert)
		else $error("receive timing differs in common mode");
	a_dac_hold: assert property (
		$changed(dacWord) |-> $past(txFrameSync || sys_rst || !codecResetN))
		else $error("converter word changed without traffic");
endmodule
`default_nettype wire

// >>> bench/ccrl_host_model.sv
// host serial port model: shifts queued words into the codec
`timescale 1ns/10ps
`default_nettype none
module ccrl_host_model (
	// clock
	input  wire logic clock,
	// codec timing
	input  wire logic shiftClk,
	input  wire logic txConvert,
	// host data
	output var  logic serialDataIn,
	output var  logic idle
);
	logic [15:0] q[$];
	logic [15:0] sh, pri;
	logic        sk, act, sec, fresh;
	int          n, gap;

	initial begin
		{sh, pri, sk, act, sec, fresh, idle} = '0;
		n = 0;
		gap = 0;
	end
	// next msb is presented before the frame, so the first sample never races
	assign serialDataIn = sh[15];
	always @(posedge clock) begin
		sk <= shiftClk;
		idle <= !act && !fresh && q.size() == 0;
		if (!act) begin
			if (txConvert) begin
				act <= 1'b1;
				fresh <= 1'b0;
			end else if (!fresh && q.size() > 0) begin
				pri = q.pop_front();
				sh <= pri;
				fresh <= 1'b1;
			end
		end else if (sk && !shiftClk) begin
			if (gap > 0) begin
				gap <= gap - 1;
			end else if (n < 15) begin
				n <= n + 1;
				sh <= {sh[14:0], ~sh[14]};
			end else begin
				n <= 0;
				if (!sec && pri[1:0] == 2'h3) begin
					gap <= 4;
					sec <= 1'b1;
					sh <= q.pop_front();
				end else begin
					act <= 1'b0;
					sec <= 1'b0;
					pri = {pri[15:2], 2'h0}; // resend carries no command
					sh <= pri;
				end
			end
		end
	end
endmodule
`default_nettype wire

// >>> bench/testbench.sv
// self-checking bench for the codec rate and configuration logic
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic                 clock, sys_rst, codecResetN, wordMode, serialDataIn, hostIdle;
	logic                 shiftClk, txFrameSync, rxFrameSync, txConvert, rxConvert;
	logic                 shutdown, portStopped;
	logic [13:0]          dacWord;
	ccrl_pkg::ccrl_ctrl_t analogConfig;
	logic [31:0]          rs;
	logic [15:0]          w, lp;
	logic [5:0]           st[4] = '{6'h03, 6'h39, 6'h04, 6'h03};
	logic [1:0]           md[4] = '{2'h1, 2'h1, 2'h2, 2'h2};
	int                   ex[4] = '{203, 257, 200, 197};
	int                   n_fail, total_checks, p;

	ccrl_codec_rate_config dut_u (.clock(clock), .sys_rst(sys_rst), .codecResetN(codecResetN),
		.wordMode(wordMode), .serialDataIn(serialDataIn), .shiftClk(shiftClk),
		.txFrameSync(txFrameSync), .rxFrameSync(rxFrameSync), .dacWord(dacWord),
		.txConvert(txConvert), .rxConvert(rxConvert), .analogConfig(analogConfig),
		.shutdown(shutdown), .portStopped(portStopped));
	ccrl_host_model host_u (.clock(clock), .shiftClk(shiftClk), .txConvert(txConvert),
		.serialDataIn(serialDataIn), .idle(hostIdle));

	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	task automatic tick;
		@(posedge clock);
		#1;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	function automatic logic [15:0] rnd();
		for (int i = 0; i < 16; i++) rs = {rs[30:0], rs[31] ^ rs[21] ^ rs[1] ^ rs[0]};
		return rs[15:0];
	endfunction

	function automatic ccrl_pkg::ccrl_ctrl_t exp_ctrl(input logic [15:0] s);
		return '{s[9], s[7:6], s[5], s[4], s[3], s[2]};
	endfunction

	// clocks from the conversion strobe seen now to the next one
	task automatic per(input bit rx, output int n);
		n = 0;
		while (!(rx ? rxConvert : txConvert) && n < 3000) begin
			tick;
			n++;
		end
		n = 0;
		do begin
			tick;
			n++;
		end while (!(rx ? rxConvert : txConvert) && n < 3000);
		if (n >= 3000) n_fail++;
	endtask

	task automatic send(input logic [15:0] w1, input logic [15:0] w2);
		int t;
		t = 0;
		host_u.q.push_back(w1);
		if (w1[1:0] == 2'h3) host_u.q.push_back(w2);
		repeat (2) tick;
		while (!hostIdle && t < 3000) begin
			tick;
			t++;
		end
		if (t >= 3000) n_fail++;
		repeat (4) tick;
	endtask

	task automatic cfg(input logic [15:0] s);
		lp = rnd();
		lp[1:0] = 2'h3;
		send(lp, s);
	endtask

	task automatic close_out;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge clock);
		n_fail++;
		close_out;
	end

	initial begin
		{sys_rst, codecResetN, wordMode, n_fail, total_checks, rs} = {3'b111, 64'h0, 32'hA50C};
		repeat (16) tick;
		sys_rst = 1'b0;
		chk(16'(analogConfig), 16'(ccrl_pkg::RST_CTRL));
		per(0, p);
		per(0, p);
		chk(16'(p), 16'd324);
		per(1, p);
		chk(16'(p), 16'd324);
		chk(16'(rxFrameSync), 16'h1);
		$display("reset test done");
		for (int i = 0; i < 6; i++) begin
			w = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0003 : rnd();
			w[1:0] = 2'h3;
			cfg(w);
			chk(16'(analogConfig), 16'(exp_ctrl(w)));
			chk(16'(dacWord), 16'(lp[15:2]));
		end
		$display("control test done");
		cfg(16'h0003);
		cfg({2'h0, 5'h05, 2'h0, 5'h07, 2'h0});
		// every period programmed outlasts a full frame pair
		cfg({1'h0, 6'h28, 1'h0, 6'h01, 2'h2});
		per(0, p);
		per(0, p);
		chk(16'(p), 16'd200);
		per(1, p);
		per(1, p);
		chk(16'(p), 16'd252);
		cfg(16'h0023);
		per(1, p);
		per(1, p);
		chk(16'(p), 16'd200);
		$display("divider test done");
		for (int k = 0; k < 4; k++) begin
			cfg({1'h0, st[k], 1'h0, st[k], 2'h1});
			per(0, p);
			w = rnd();
			w[1:0] = md[k];
			host_u.q.push_back(w);
			// the word queued at a strobe goes out one period later
			per(0, p);
			per(0, p);
			chk(16'(p), 16'(ex[k]));
			per(0, p);
			chk(16'(p), 16'd200);
			chk(16'(dacWord), 16'(w[15:2]));
		end
		$display("adjust test done");
		cfg({2'h0, 5'h04, 2'h0, 5'h09, 2'h0});
		chk(16'(portStopped), 16'h0);
		wordMode = 1'b0;
		repeat (4) tick;
		chk(16'(portStopped), 16'h1);
		per(0, p);
		per(0, p);
		chk(16'(dacWord), 16'(lp[15:2]));
		chk(16'(rxFrameSync), 16'h0);
		wordMode = 1'b1;
		repeat (40) tick;
		chk(16'(portStopped), 16'h0);
		cfg({2'h0, 5'h01, 2'h0, 5'h09, 2'h0});
		chk(16'(shutdown), 16'h1);
		codecResetN = 1'b0;
		tick;
		codecResetN = 1'b1;
		tick;
		chk(16'(analogConfig), 16'(ccrl_pkg::RST_CTRL));
		chk(16'(shutdown), 16'h0);
		per(0, p);
		per(0, p);
		chk(16'(p), 16'd324);
		$display("limit test done");
		close_out;
	end
endmodule

bind ccrl_codec_rate_config ccrl_checker chk_u (.clock(clock), .sys_rst(sys_rst),
	.codecResetN(codecResetN), .shiftClk(shiftClk), .txFrameSync(txFrameSync),
	.txConvert(txConvert), .rxConvert(rxConvert), .dacWord(dacWord),
	.analogConfig(analogConfig), .shutdown(shutdown), .portStopped(portStopped));
`default_nettype wire

// >>> core/ccrl_codec_rate_config.sv
// conversion timing, serial word decode and configuration registers of the codec
`timescale 1ns/10ps
`default_nettype none

//
// Contract
// - code 00 loads both A dividers
// - code 01 loads signed step adjusts
// - code 10 loads both B dividers
// - code 11 loads control from d9,d7..d2
// - d2 removes or inserts high-pass section
// - d3 loopback, d4 second input pair
// - d5 selects independent or common timing
// - d6,d7 form input gain field
// - d9 removes or inserts sinc correction
// - reset pulse loads divider and step defaults
// - reset loads control register defaults
// - common timing uses transmit registers only; shutdown and port stop still test the receive A divider
// - adjusted sum 0 or 1 uses plain divider
// - negative sum is taken modulo 64
// - A divider 0 or 1 shuts down
// - A divider below limit stops serial port
// - B divider written 0 or 1 becomes 24h
// - hold last output value without traffic
// - adjustment applied near end of period
// - one command adjusts one period pair
// - receive adjust goes to period A or B
// - primary code 11 brings secondary after four shifts
// - B reloads every period, shift clock is clock/4
module ccrl_codec_rate_config (
	// clock and reset
	input  wire logic                   clock,
	input  wire logic                   sys_rst,
	input  wire logic                   codecResetN,
	// strap
	input  wire logic                   wordMode,
	// serial port
	input  wire logic                   serialDataIn,
	output var  logic                   shiftClk,
	output var  logic                   txFrameSync,
	output var  logic                   rxFrameSync,
	// converter side
	output var  logic [13:0]            dacWord,
	output var  logic                   txConvert,
	output var  logic                   rxConvert,
	// configuration
	output var  ccrl_pkg::ccrl_ctrl_t   analogConfig,
	output var  logic                   shutdown,
	output var  logic                   portStopped
);

	logic                              rstAll;
	logic [1:0]                        phase_r;
	logic                              shiftTick;
	ccrl_pkg::ccrl_state_t             state_r;
	logic [3:0]                        bitCnt_r;
	logic [ccrl_pkg::WORD_W-1:0]       shift_r;
	logic [ccrl_pkg::WORD_W-1:0]       wordIn;
	logic                              wordDone;
	logic                              primDone;
	logic                              secDone;
	logic [ccrl_pkg::DIVA_W-1:0]       divA_r [2];
	logic [ccrl_pkg::STEP_W-1:0]       step_r [2];
	logic [ccrl_pkg::DIVB_W-1:0]       divB_r [2];
	ccrl_pkg::ccrl_ctrl_t              ctrl_r;
	logic                              adjCmd_r;
	ccrl_pkg::ccrl_adj_t               adjMode_r;
	logic [1:0]                        convNow;
	logic                              shutdown_r;
	logic                              portStop_r;
	logic [13:0]                       dac_r;
	logic                              txConv_r;
	logic                              rxConv_r;
	logic                              shiftClk_r;
	logic                              txSync_r;
	logic                              rxSync_r;

	// both reset sources act on the clock edge
	assign rstAll = sys_rst | ~codecResetN;

	function automatic logic lowVal(input logic [ccrl_pkg::DIVB_W-1:0] v);
		lowVal = (v < 6'h02);
	endfunction

	// counter A load for one period, adjusted or not
	function automatic logic [ccrl_pkg::CNTA_W-1:0] aLoad(
		input logic [ccrl_pkg::DIVA_W-1:0] divA,
		input logic [ccrl_pkg::STEP_W-1:0] step,
		input ccrl_pkg::ccrl_adj_t         mode
	);
		logic signed [7:0] base;
		logic signed [7:0] delta;
		logic signed [7:0] sum;
		base  = signed'({3'h0, divA});
		delta = signed'({{2{step[ccrl_pkg::STEP_W-1]}}, step});
		case (mode)
			ccrl_pkg::ADJ_PLUS: begin
				sum = base + delta;
			end
			ccrl_pkg::ADJ_MINUS: begin
				sum = base - delta;
			end
			default: begin
				sum = base;
			end
		endcase
		if (sum == 8'sh00 || sum == 8'sh01) begin
			aLoad = {1'h0, divA};
		end else if (sum < 8'sh00) begin
			aLoad = 6'(sum + ccrl_pkg::MOD_ADD);
		end else begin
			aLoad = sum[ccrl_pkg::CNTA_W-1:0];
		end
	endfunction

	// shift clock divider, free running
	always_ff @(posedge clock) begin
		if (rstAll) begin
			phase_r <= 2'h0;
		end else begin
			phase_r <= phase_r + 2'h1;
		end
	end

	assign shiftTick = (phase_r == ccrl_pkg::SHIFT_LAST);

	always_ff @(posedge clock) begin
		if (rstAll) begin
			shiftClk_r <= 1'h0;
		end else begin
			shiftClk_r <= (phase_r == 2'h1) | (phase_r == 2'h2);
		end
	end

	// error states from the divider contents
	always_ff @(posedge clock) begin
		if (rstAll) begin
			shutdown_r <= 1'h0;
			portStop_r <= 1'h0;
		end else begin
			shutdown_r <= lowVal({1'h0, divA_r[0]}) | lowVal({1'h0, divA_r[1]});
			if (wordMode) begin
				portStop_r <= (divA_r[0] < ccrl_pkg::MIN_A_WORD) |
					(divA_r[1] < ccrl_pkg::MIN_A_WORD);
			end else begin
				portStop_r <= (divA_r[0] < ccrl_pkg::MIN_A_BYTE) |
					(divA_r[1] < ccrl_pkg::MIN_A_BYTE);
			end
		end
	end

	// serial frame engine, one frame per transmit conversion
	assign wordIn   = {shift_r[ccrl_pkg::WORD_W-2:0], serialDataIn};
	assign wordDone = shiftTick & (bitCnt_r == ccrl_pkg::LAST_BIT);
	assign primDone = wordDone & (state_r == ccrl_pkg::ST_PRIMARY);
	assign secDone  = wordDone & (state_r == ccrl_pkg::ST_SECONDARY);

	always_ff @(posedge clock) begin
		if (rstAll) begin
			state_r  <= ccrl_pkg::ST_IDLE;
			bitCnt_r <= 4'h0;
		end else begin
			case (state_r)
				ccrl_pkg::ST_IDLE: begin
					bitCnt_r <= 4'h0;
					// a stopped port starts no frames
					if (convNow[0] && !portStop_r && !shutdown_r) begin
						state_r <= ccrl_pkg::ST_PRIMARY;
					end
				end
				ccrl_pkg::ST_PRIMARY: begin
					if (shiftTick) begin
						bitCnt_r <= bitCnt_r + 4'h1;
					end
					if (primDone) begin
						bitCnt_r <= 4'h0;
						if (wordIn[1:0] == ccrl_pkg::PRI_SECOND) begin
							state_r <= ccrl_pkg::ST_GAP;
						end else begin
							state_r <= ccrl_pkg::ST_IDLE;
						end
					end
				end
				ccrl_pkg::ST_GAP: begin
					if (shiftTick) begin
						if (bitCnt_r == ccrl_pkg::GAP_SHIFTS - 4'h1) begin
							bitCnt_r <= 4'h0;
							state_r  <= ccrl_pkg::ST_SECONDARY;
						end else begin
							bitCnt_r <= bitCnt_r + 4'h1;
						end
					end
				end
				ccrl_pkg::ST_SECONDARY: begin
					if (shiftTick) begin
						bitCnt_r <= bitCnt_r + 4'h1;
					end
					if (secDone) begin
						bitCnt_r <= 4'h0;
						state_r  <= ccrl_pkg::ST_IDLE;
					end
				end
				default: begin
					state_r  <= ccrl_pkg::ST_IDLE;
					bitCnt_r <= 4'h0;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (rstAll) begin
			shift_r <= 16'h0000;
		end else if (shiftTick) begin
			shift_r <= wordIn;
		end
	end

	always_ff @(posedge clock) begin
		if (rstAll) begin
			txSync_r <= 1'h0;
		end else begin
			txSync_r <= (state_r == ccrl_pkg::ST_PRIMARY) | (state_r == ccrl_pkg::ST_SECONDARY);
		end
	end

	// the output word only changes on a primary word, so it holds otherwise
	always_ff @(posedge clock) begin
		if (rstAll) begin
			dac_r <= 14'h0000;
		end else if (primDone) begin
			dac_r <= wordIn[ccrl_pkg::WORD_W-1:ccrl_pkg::DAC_LSB];
		end
	end

	// adjust command from the primary word low bits
	always_ff @(posedge clock) begin
		if (rstAll) begin
			adjCmd_r  <= 1'h0;
			adjMode_r <= ccrl_pkg::ADJ_NONE;
		end else begin
			adjCmd_r <= primDone &
				((wordIn[1:0] == ccrl_pkg::PRI_PLUS) | (wordIn[1:0] == ccrl_pkg::PRI_MINUS));
			if (primDone && wordIn[1:0] == ccrl_pkg::PRI_PLUS) begin
				adjMode_r <= ccrl_pkg::ADJ_PLUS;
			end else if (primDone && wordIn[1:0] == ccrl_pkg::PRI_MINUS) begin
				adjMode_r <= ccrl_pkg::ADJ_MINUS;
			end
		end
	end

	// secondary decode into the divider registers
	always_ff @(posedge clock) begin
		if (rstAll) begin
			divA_r[0] <= ccrl_pkg::RST_DIVA;
			divA_r[1] <= ccrl_pkg::RST_DIVA;
			step_r[0] <= ccrl_pkg::RST_STEP;
			step_r[1] <= ccrl_pkg::RST_STEP;
			divB_r[0] <= ccrl_pkg::RST_DIVB;
			divB_r[1] <= ccrl_pkg::RST_DIVB;
		end else if (secDone) begin
			case (wordIn[1:0])
				ccrl_pkg::SEC_DIVA: begin
					divA_r[0] <= wordIn[ccrl_pkg::TXA_MSB:ccrl_pkg::TXA_LSB];
					divA_r[1] <= wordIn[ccrl_pkg::RXA_MSB:ccrl_pkg::RXA_LSB];
				end
				ccrl_pkg::SEC_STEP: begin
					step_r[0] <= wordIn[ccrl_pkg::TXS_MSB:ccrl_pkg::TXS_LSB];
					step_r[1] <= wordIn[ccrl_pkg::RXS_MSB:ccrl_pkg::RXS_LSB];
				end
				ccrl_pkg::SEC_DIVB: begin
					// an unusable B count is replaced, never stored
					divB_r[0] <= lowVal(wordIn[ccrl_pkg::TXS_MSB:ccrl_pkg::TXS_LSB]) ?
						ccrl_pkg::FIX_DIVB : wordIn[ccrl_pkg::TXS_MSB:ccrl_pkg::TXS_LSB];
					divB_r[1] <= lowVal(wordIn[ccrl_pkg::RXS_MSB:ccrl_pkg::RXS_LSB]) ?
						ccrl_pkg::FIX_DIVB : wordIn[ccrl_pkg::RXS_MSB:ccrl_pkg::RXS_LSB];
				end
				default: begin
				end
			endcase
		end
	end

	// control register, other bit positions are dropped
	always_ff @(posedge clock) begin
		if (rstAll) begin
			ctrl_r <= ccrl_pkg::RST_CTRL;
		end else if (secDone && wordIn[1:0] == ccrl_pkg::SEC_CTRL) begin
			ctrl_r.hpf      <= wordIn[ccrl_pkg::CTL_HPF];
			ctrl_r.loopback <= wordIn[ccrl_pkg::CTL_LOOP];
			ctrl_r.auxIn    <= wordIn[ccrl_pkg::CTL_AUX];
			ctrl_r.common   <= wordIn[ccrl_pkg::CTL_COMMON];
			ctrl_r.gain     <= wordIn[ccrl_pkg::CTL_GAIN_M:ccrl_pkg::CTL_GAIN_L];
			ctrl_r.sincCorr <= wordIn[ccrl_pkg::CTL_SINC];
		end
	end

	// conversion timing, index 0 transmit and 1 receive
	for (genvar g = 0; g < 2; g++) begin : gSide
		logic [ccrl_pkg::CNTA_W-1:0] cntA_r;
		logic [ccrl_pkg::DIVB_W-1:0] cntB_r;
		ccrl_pkg::ccrl_adj_t         pend_r;
		logic [ccrl_pkg::DIVA_W-1:0] selA;
		logic [ccrl_pkg::STEP_W-1:0] selS;
		logic [ccrl_pkg::DIVB_W-1:0] selB;
		logic                        aDone;
		logic [ccrl_pkg::DIVB_W-1:0] nextB;
		logic                        lastSeg;
		logic                        take;
		logic                        busy;

		// receive follows transmit registers in common mode
		assign selA = (g == 1 && ctrl_r.common) ? divA_r[0] : divA_r[g];
		assign selS = (g == 1 && ctrl_r.common) ? step_r[0] : step_r[g];
		assign selB = (g == 1 && ctrl_r.common) ? divB_r[0] : divB_r[g];

		assign aDone   = (cntA_r <= 6'h01);
		assign nextB   = (cntB_r <= 6'h01) ? selB : cntB_r - 6'h01;
		assign lastSeg = (nextB == 6'h01);
		assign take    = aDone & lastSeg & (pend_r != ccrl_pkg::ADJ_NONE);
		assign busy    = (cntB_r == 6'h01) | take;
		assign convNow[g] = aDone & (cntB_r <= 6'h01) & ~shutdown_r;

		always_ff @(posedge clock) begin
			if (rstAll) begin
				cntA_r <= {1'h0, ccrl_pkg::RST_DIVA};
				cntB_r <= ccrl_pkg::RST_DIVB;
			end else if (!shutdown_r && aDone) begin
				cntB_r <= nextB;
				// the adjusted count is spent on the last A segment
				if (lastSeg) begin
					cntA_r <= aLoad(selA, selS, pend_r);
				end else begin
					cntA_r <= {1'h0, selA};
				end
			end else if (!shutdown_r) begin
				cntA_r <= cntA_r - 6'h01;
			end
		end

		always_ff @(posedge clock) begin
			if (rstAll) begin
				pend_r <= ccrl_pkg::ADJ_NONE;
			end else if (adjCmd_r && (g == 0 || (pend_r == ccrl_pkg::ADJ_NONE && !busy))) begin
				// a receive period already being adjusted ignores a new command
				pend_r <= adjMode_r;
			end else if (take) begin
				pend_r <= ccrl_pkg::ADJ_NONE;
			end
		end
	end

	// converter strobes and receive sync
	always_ff @(posedge clock) begin
		if (rstAll) begin
			txConv_r <= 1'h0;
			rxConv_r <= 1'h0;
			rxSync_r <= 1'h0;
		end else begin
			txConv_r <= convNow[0];
			rxConv_r <= ctrl_r.common ? convNow[0] : convNow[1];
			rxSync_r <= (ctrl_r.common ? convNow[0] : convNow[1]) & ~portStop_r;
		end
	end

	assign shiftClk     = shiftClk_r;
	assign txFrameSync  = txSync_r;
	assign rxFrameSync  = rxSync_r;
	assign dacWord      = dac_r;
	assign txConvert    = txConv_r;
	assign rxConvert    = rxConv_r;
	assign analogConfig = ctrl_r;
	assign shutdown     = shutdown_r;
	assign portStopped  = portStop_r;

endmodule

`default_nettype wire

// >>> core/ccrl_pkg.sv
// constants, types and field layout of the codec rate and configuration logic
package ccrl_pkg;

	// widths
	localparam int WORD_W = 16;
	localparam int DIVA_W = 5;
	localparam int STEP_W = 6;
	localparam int DIVB_W = 6;
	localparam int CNTA_W = 6;

	// primary word low-bit codes
	localparam logic [1:0] PRI_NORMAL = 2'h0;
	localparam logic [1:0] PRI_PLUS   = 2'h1;
	localparam logic [1:0] PRI_MINUS  = 2'h2;
	localparam logic [1:0] PRI_SECOND = 2'h3;

	// secondary word low-bit codes
	localparam logic [1:0] SEC_DIVA = 2'h0;
	localparam logic [1:0] SEC_STEP = 2'h1;
	localparam logic [1:0] SEC_DIVB = 2'h2;
	localparam logic [1:0] SEC_CTRL = 2'h3;

	// secondary field positions and primary data low bit
	localparam int TXA_MSB = 13;
	localparam int TXA_LSB = 9;
	localparam int RXA_MSB = 6;
	localparam int RXA_LSB = 2;
	localparam int TXS_MSB = 14;
	localparam int TXS_LSB = 9;
	localparam int RXS_MSB = 7;
	localparam int RXS_LSB = 2;
	localparam int DAC_LSB = 2;

	// control bit positions
	localparam int CTL_HPF    = 2;
	localparam int CTL_LOOP   = 3;
	localparam int CTL_AUX    = 4;
	localparam int CTL_COMMON = 5;
	localparam int CTL_GAIN_L = 6;
	localparam int CTL_GAIN_M = 7;
	localparam int CTL_SINC   = 9;

	// reset and fix-up values
	localparam logic [DIVA_W-1:0] RST_DIVA  = 5'h09;
	localparam logic [STEP_W-1:0] RST_STEP  = 6'h01;
	localparam logic [DIVB_W-1:0] RST_DIVB  = 6'h24;
	localparam logic [DIVB_W-1:0] FIX_DIVB  = 6'h24;
	localparam logic signed [7:0] MOD_ADD   = 8'sh40;

	// limits and timing
	localparam logic [DIVA_W-1:0] MIN_A_WORD  = 5'h04;
	localparam logic [DIVA_W-1:0] MIN_A_BYTE  = 5'h05;
	localparam logic [1:0]        SHIFT_LAST  = 2'h3;
	localparam logic [3:0]        GAP_SHIFTS  = 4'h4;
	localparam logic [3:0]        LAST_BIT    = 4'hF;

	typedef enum logic [1:0] {ST_IDLE, ST_PRIMARY, ST_GAP, ST_SECONDARY} ccrl_state_t;
	typedef enum logic [1:0] {ADJ_NONE, ADJ_PLUS, ADJ_MINUS} ccrl_adj_t;

	typedef struct packed {
		logic       sincCorr;
		logic [1:0] gain;
		logic       common;
		logic       auxIn;
		logic       loopback;
		logic       hpf;
	} ccrl_ctrl_t;

	localparam ccrl_ctrl_t RST_CTRL = '{1'h1, 2'h3, 1'h1, 1'h0, 1'h0, 1'h1};

endpackage
